//--- core/ivp_defs.vh
// Purpose: Constants for the interrupt vector and priority block
// Assumes: 16-bit register port, byte-free word addressing
// Notes:   Offsets are word indices on the plain register port
`ifndef IVP_DEFS_VH
`define IVP_DEFS_VH

// Register port widths and number of sources
`define IVP_AW 8
`define IVP_DW 16
`define IVP_NSRC 14

// Register offsets
`define IVP_MASK_ADDR 8'h00
`define IVP_FLAG_ADDR 8'h01
`define IVP_DSEL_ADDR 8'h02
`define IVP_STAT_ADDR 8'h03

// Reset values
`define IVP_MASK_RST 14'h0000
`define IVP_FLAG_RST 14'h0000
`define IVP_DSEL_RST 4'h0

// Flag and mask bit positions
`define IVP_BIT_EXT0 0
`define IVP_BIT_EXT1 1
`define IVP_BIT_EXT2 2
`define IVP_BIT_TMR0 3
`define IVP_BIT_S0RX 4
`define IVP_BIT_S0TX 5
`define IVP_BIT_SH0 6
`define IVP_BIT_SH1 7
`define IVP_BIT_EXT3 8
`define IVP_BIT_HOST 9
`define IVP_BIT_SH2 10
`define IVP_BIT_SH3 11
`define IVP_BIT_DMA4 12
`define IVP_BIT_DMA5 13

// Vector offsets and priorities
`define IVP_VEC_RESET 7'h00
`define IVP_VEC_NMI 7'h04
`define IVP_VEC_HWBASE 7'h40
`define IVP_VEC_SHIFT 2
`define IVP_PRIO_RESET 5'h01
`define IVP_PRIO_NMI 5'h02
`define IVP_PRIO_HWBASE 5'h03

// Software trap numbers
`define IVP_TRAP_NMI 5'h10
`define IVP_TRAP_SWLO 5'h11
`define IVP_TRAP_SWHI 5'h1E

// Kinds of the request on offer
`define IVP_KIND_RESET 2'h0
`define IVP_KIND_NMI 2'h1
`define IVP_KIND_HW 2'h2

`endif

//--- core/ivp_irq_vector.v
// Purpose: Flag, mask, shared-slot select and priority vectoring
// Assumes: One 100 MHz clock; all inputs synchronous to it
// Notes:   Sources are one-cycle event pulses; the core acks a request
`timescale 1ns/1ps
`include "ivp_defs.vh"

// Operation
// R1 - Vector slots sit four words apart; slot index times four is offset.
// R2 - Reset vectors to 00 at priority 1; nonmaskable to 04 at priority 2.
// R3 - External 0,1,2 at 40,44,48 priorities 3-5; timer 0 at 4C priority 6.
// R4 - Serial port 0 receive vectors to 50 with priority 7.
// R5 - Serial port 0 transmit vectors to 54 with priority 8.
// R6 - Slot 58 priority 9 reserved unless selected for DMA channel 0.
// R7 - Slot 5C priority 10 is timer 1, or DMA channel 1 when selected.
// R8 - External 3 at 60 priority 11; host port at 64 priority 12.
// R9 - Slot 68 priority 13 is serial 1 receive, or DMA channel 2.
// R10 - Slot 6C priority 14 is serial 1 transmit, or DMA channel 3.
// R11 - DMA channel 4 owns slot 70 with priority 15.
// R12 - DMA channel 5 owns slot 74 with priority 16, the lowest.
// R13 - Flag and mask use bits 0-13; 15-14 reserved; shared bits follow select.
// R14 - Smallest priority number wins; vectors 08-3C only entered by trap.
// R15 - Offsets 78 to 7F are never chosen by any hardware source.
module ivp_irq_vector (
  input  wire        core_clk,        // Processor clock
  input  wire        rst_b,           // Synchronous reset, active low
  input  wire [7:0]  regAddr,         // Register word index
  input  wire [15:0] regWrData,       // Register write data
  input  wire        regWrEn,         // Write strobe
  input  wire        regRdEn,         // Read strobe
  output reg  [15:0] regRdData_r,     // Read data, cycle after strobe
  input  wire        hwResetReq,      // Hardware reset event
  input  wire        softResetReq,    // Software reset event
  input  wire        nmiReq,          // Nonmaskable event
  input  wire        ext_user_irq_0,  // External event 0
  input  wire        ext_user_irq_1,  // External event 1
  input  wire        ext_user_irq_2,  // External event 2
  input  wire        ext_user_irq_3,  // External event 3
  input  wire        timer_zero_irq,  // Timer 0 event
  input  wire        timer_one_irq,   // Timer 1 event
  input  wire        serial0_rx_irq,  // Serial 0 receive event
  input  wire        serial0_tx_irq,  // Serial 0 transmit event
  input  wire        serial1_rx_irq,  // Serial 1 receive event
  input  wire        serial1_tx_irq,  // Serial 1 transmit event
  input  wire        host_port_irq,   // Host port event
  input  wire [5:0]  dmaChIrq,        // DMA channel 5..0 events
  input  wire        cpuIntEnable,    // Core global enable for maskables
  input  wire        irqAck,          // Core takes the offered vector
  input  wire        soft_vector_trap, // Instruction trap pulse
  input  wire [4:0]  trapNum,         // Trap number 0..30
  output reg         irqReq_r,        // Request to the core
  output reg  [6:0]  irqVec_r,        // Offered vector offset
  output reg  [4:0]  irqPrio_r,       // Offered priority number
  output reg         trapVld_r,       // Trap vector valid pulse
  output reg  [6:0]  trapVec_r        // Trap vector offset
);

  reg  [13:0] irq_mask_reg_r;         // Mask, one bit per slot
  reg  [13:0] irq_flag_reg_r;         // Sticky flags
  reg  [3:0]  dma_priority_enable_control_r; // Shared slot select
  reg         resetPend_r;            // Reset waiting for core
  reg         nmiPend_r;              // Nonmaskable waiting
  reg  [1:0]  curKind_r;              // Kind of the offered request
  reg  [3:0]  curIdx_r;               // Slot of the offered request
  reg  [13:0] evt;                    // Events routed to flag bits
  wire [13:0] flagNxt;                // Next flag state
  reg         irqReqNxt;              // Next request to the core
  reg  [6:0]  irqVecNxt;              // Next offered vector
  reg  [4:0]  irqPrioNxt;             // Next offered priority
  reg  [1:0]  kindNxt;                // Next kind of the offer
  reg  [3:0]  idxNxt;                 // Next slot of the offer
  reg  [13:0] maskNxt;                // Next mask state
  reg  [3:0]  dselNxt;                // Next select state
  reg  [15:0] rdMux;                  // Read data source
  reg  [3:0]  winIdx;                 // Winning slot
  reg         winAny;                 // Some slot pending
  reg  [6:0]  trapVecNxt;             // Trap vector lookup
  reg         trapOk;                 // Trap number legal
  wire [13:0] pendNxt;                // Enabled, unmasked, pending
  wire [13:0] flagClr;                // Per-bit clear requests
  wire        ackNow;                 // Core takes the offer now
  wire        ackReset;               // Reset request consumed
  wire        ackNmi;                 // Nonmaskable consumed
  wire        ackHw;                  // Maskable request consumed
  wire        flagWr;                 // Flag register write
  wire        resetNxt;               // Next reset pending
  wire        nmiNxt;                 // Next nonmaskable pending
  wire [3:0]  dsel;                   // Short name for the select

  assign dsel = dma_priority_enable_control_r;

  // Route sources onto flag bits; shared bits follow the select
  always @*
  begin
    evt = 14'h0000;
    evt[`IVP_BIT_EXT0] = ext_user_irq_0;                         // [R3]
    evt[`IVP_BIT_EXT1] = ext_user_irq_1;                         // [R3]
    evt[`IVP_BIT_EXT2] = ext_user_irq_2;                         // [R3]
    evt[`IVP_BIT_TMR0] = timer_zero_irq;                         // [R3]
    evt[`IVP_BIT_S0RX] = serial0_rx_irq;                         // [R4]
    evt[`IVP_BIT_S0TX] = serial0_tx_irq;                         // [R5]
    // Reserved bit stays quiet unless DMA owns it
    evt[`IVP_BIT_SH0] = dsel[0] & dmaChIrq[0];                   // [R6] [R13]
    evt[`IVP_BIT_SH1] = dsel[1] ? dmaChIrq[1] : timer_one_irq;   // [R7] [R13]
    evt[`IVP_BIT_EXT3] = ext_user_irq_3;                         // [R8]
    evt[`IVP_BIT_HOST] = host_port_irq;                          // [R8]
    evt[`IVP_BIT_SH2] = dsel[2] ? dmaChIrq[2] : serial1_rx_irq;  // [R9] [R13]
    evt[`IVP_BIT_SH3] = dsel[3] ? dmaChIrq[3] : serial1_tx_irq;  // [R10] [R13]
    evt[`IVP_BIT_DMA4] = dmaChIrq[4];                            // [R11]
    evt[`IVP_BIT_DMA5] = dmaChIrq[5];                            // [R12]
  end

  // Acknowledge decode against the request already on offer
  assign ackNow = irqAck & irqReq_r;
  assign ackReset = ackNow & (curKind_r == `IVP_KIND_RESET);
  assign ackNmi = ackNow & (curKind_r == `IVP_KIND_NMI);
  assign ackHw = ackNow & (curKind_r == `IVP_KIND_HW);
  assign flagWr = regWrEn & (regAddr == `IVP_FLAG_ADDR);

  // Per-bit flag update; a new event beats any clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < `IVP_NSRC; gi = gi + 1)
    begin : gFlag
      assign flagClr[gi] = (flagWr & regWrData[gi]) |
                           (ackHw & (curIdx_r == gi));
      assign flagNxt[gi] = evt[gi] |
                           (irq_flag_reg_r[gi] & ~flagClr[gi]);
    end
  endgenerate

  // Reset outranks everything; set wins over the acknowledge
  assign resetNxt = hwResetReq | softResetReq |
                    (resetPend_r & ~ackReset);                   // [R2]
  assign nmiNxt = nmiReq | (nmiPend_r & ~ackNmi);                // [R2]

  // Only enabled and unmasked flags compete
  assign pendNxt = flagNxt & irq_mask_reg_r &
                   {`IVP_NSRC{cpuIntEnable}};

  // Lowest bit is the smallest priority number
  integer k;
  always @*
  begin
    winIdx = 4'h0;
    winAny = 1'b0;
    for (k = `IVP_NSRC - 1; k >= 0; k = k - 1)
    begin
      if (pendNxt[k])
      begin
        winIdx = k[3:0];                                          // [R14]
        winAny = 1'b1;
      end
    end
  end

  // Trap lookup as a full table; a table is easier to audit than
  // arithmetic, and numbers landing on reserved space are dropped
  always @*
  begin
    trapOk = 1'b1;
    trapVecNxt = `IVP_VEC_RESET;
    case (trapNum)
      // Reset and nonmaskable entries
      5'h00: trapVecNxt = `IVP_VEC_RESET;                         // [R2]
      5'h10: trapVecNxt = `IVP_VEC_NMI;                           // [R2]

      // Hardware slots, entered without touching any flag
      5'h01: trapVecNxt = 7'h44;                                  // [R1]
      5'h02: trapVecNxt = 7'h48;                                  // [R1]
      5'h03: trapVecNxt = 7'h4C;                                  // [R1]
      5'h04: trapVecNxt = 7'h50;                                  // [R1]
      5'h05: trapVecNxt = 7'h54;                                  // [R1]
      5'h06: trapVecNxt = 7'h58;                                  // [R1]
      5'h07: trapVecNxt = 7'h5C;                                  // [R1]
      5'h08: trapVecNxt = 7'h60;                                  // [R1]
      5'h09: trapVecNxt = 7'h64;                                  // [R1]
      5'h0A: trapVecNxt = 7'h68;                                  // [R1]
      5'h0B: trapVecNxt = 7'h6C;                                  // [R1]
      5'h0C: trapVecNxt = 7'h70;                                  // [R1]
      5'h0D: trapVecNxt = 7'h74;                                  // [R1]

      // Software-only slots, reachable by instruction alone
      5'h11: trapVecNxt = 7'h08;                                  // [R14]
      5'h12: trapVecNxt = 7'h0C;                                  // [R14]
      5'h13: trapVecNxt = 7'h10;                                  // [R14]
      5'h14: trapVecNxt = 7'h14;                                  // [R14]
      5'h15: trapVecNxt = 7'h18;                                  // [R14]
      5'h16: trapVecNxt = 7'h1C;                                  // [R14]
      5'h17: trapVecNxt = 7'h20;                                  // [R14]
      5'h18: trapVecNxt = 7'h24;                                  // [R14]
      5'h19: trapVecNxt = 7'h28;                                  // [R14]
      5'h1A: trapVecNxt = 7'h2C;                                  // [R14]
      5'h1B: trapVecNxt = 7'h30;                                  // [R14]
      5'h1C: trapVecNxt = 7'h34;                                  // [R14]
      5'h1D: trapVecNxt = 7'h38;                                  // [R14]
      5'h1E: trapVecNxt = 7'h3C;                                  // [R14]

      // Numbers 14, 15 and 31 have no slot and give no pulse
      default:
      begin
        trapOk = 1'b0;                                            // [R15]
      end
    endcase
  end

  // Register write next values; reserved bits are not stored
  always @*
  begin
    maskNxt = irq_mask_reg_r;
    dselNxt = dsel;
    if (regWrEn && regAddr == `IVP_MASK_ADDR)
    begin
      maskNxt = regWrData[13:0];                                  // [R13]
    end
    if (regWrEn && regAddr == `IVP_DSEL_ADDR)
    begin
      dselNxt = regWrData[3:0];
    end
  end

  // Read mux; reserved bits and unmapped words read zero
  always @*
  begin
    case (regAddr)
      `IVP_MASK_ADDR: rdMux = {2'b00, irq_mask_reg_r};            // [R13]
      `IVP_FLAG_ADDR: rdMux = {2'b00, irq_flag_reg_r};            // [R13]
      `IVP_DSEL_ADDR: rdMux = {12'h000, dsel};
      `IVP_STAT_ADDR: rdMux = {irqReq_r, resetPend_r, nmiPend_r,
                               1'b0, irqPrio_r, irqVec_r};
      default:        rdMux = 16'h0000;
    endcase
  end

  // Register file and pending state
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irq_mask_reg_r <= `IVP_MASK_RST;
      irq_flag_reg_r <= `IVP_FLAG_RST;
      dma_priority_enable_control_r <= `IVP_DSEL_RST;
      resetPend_r <= 1'b0;
      nmiPend_r <= 1'b0;
      regRdData_r <= 16'h0000;
    end
    else
    begin
      irq_mask_reg_r <= maskNxt;
      irq_flag_reg_r <= flagNxt;
      dma_priority_enable_control_r <= dselNxt;
      resetPend_r <= resetNxt;
      nmiPend_r <= nmiNxt;
      // Data stand only in the cycle after the strobe
      regRdData_r <= regRdEn ? rdMux : 16'h0000;
    end
  end

  // Offer is rebuilt from next state so an acked source never repeats;
  // reset outranks the nonmaskable, which outranks every maskable
  always @*
  begin
    irqReqNxt = 1'b0;
    irqVecNxt = `IVP_VEC_RESET;
    irqPrioNxt = 5'h00;
    kindNxt = `IVP_KIND_HW;
    idxNxt = 4'h0;
    if (resetNxt)
    begin
      irqReqNxt = 1'b1;
      irqVecNxt = `IVP_VEC_RESET;                                 // [R2]
      irqPrioNxt = `IVP_PRIO_RESET;                               // [R2]
      kindNxt = `IVP_KIND_RESET;
    end
    else if (nmiNxt)
    begin
      irqReqNxt = 1'b1;
      irqVecNxt = `IVP_VEC_NMI;                                   // [R2]
      irqPrioNxt = `IVP_PRIO_NMI;                                 // [R2]
      kindNxt = `IVP_KIND_NMI;
    end
    else if (winAny)
    begin
      // Index at most 13, so offsets stop at 74
      irqReqNxt = 1'b1;
      irqVecNxt = `IVP_VEC_HWBASE +
                  {1'b0, winIdx, 2'b00};                          // [R1] [R15]
      irqPrioNxt = `IVP_PRIO_HWBASE + {1'b0, winIdx};             // [R14]
      idxNxt = winIdx;
    end
  end

  // Offer registers; outputs come straight from these flops
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irqReq_r <= 1'b0;
      irqVec_r <= `IVP_VEC_RESET;
      irqPrio_r <= 5'h00;
      curKind_r <= `IVP_KIND_RESET;
      curIdx_r <= 4'h0;
    end
    else
    begin
      irqReq_r <= irqReqNxt;
      irqVec_r <= irqVecNxt;
      irqPrio_r <= irqPrioNxt;
      curKind_r <= kindNxt;
      curIdx_r <= idxNxt;
    end
  end

  // Trap path bypasses flags and masks entirely
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      trapVld_r <= 1'b0;
      trapVec_r <= `IVP_VEC_RESET;
    end
    else
    begin
      trapVld_r <= soft_vector_trap & trapOk;                     // [R14]
      trapVec_r <= trapVecNxt;
    end
  end

endmodule

//--- tb/ivp_props.sv
// Purpose: Port-level checks on offers, traps and read timing
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound onto every instance of the vector block
`timescale 1ns/1ps
module ivp_props (
  input logic        core_clk,         // Processor clock
  input logic        rst_b,            // Reset, active low
  input logic        regRdEn,          // Read strobe
  input logic [15:0] regRdData_r,      // Read data
  input logic        hwResetReq,       // Reset event
  input logic        nmiReq,           // Nonmaskable event
  input logic        cpuIntEnable,     // Global enable
  input logic        soft_vector_trap, // Trap pulse
  input logic [4:0]  trapNum,          // Trap number
  input logic        irqReq_r,         // Offer valid
  input logic [6:0]  irqVec_r,         // Offered vector
  input logic [4:0]  irqPrio_r,        // Offered priority
  input logic        trapVld_r,        // Trap valid
  input logic [6:0]  trapVec_r         // Trap vector
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Trap numbers split into instruction-only and unused groups
  sequence s_trap_sw;
    soft_vector_trap && trapNum >= 5'h11 && trapNum <= 5'h1E;
  endsequence
  sequence s_trap_bad;
    soft_vector_trap && trapNum inside {5'h0E, 5'h0F, 5'h1F};
  endsequence
  // Vector must follow from priority, so a wrong slot table shows up here
  a_vec_prio_pair: assert property (
    irqReq_r |-> irqPrio_r inside {[1:16]} && irqVec_r ==
    (irqPrio_r == 5'h01 ? 7'h00 : irqPrio_r == 5'h02 ? 7'h04 :
    7'h40 + {irqPrio_r - 5'h03, 2'b00}))
    else $error("offer vector does not match priority");
  a_no_sw_vec: assert property (
    irqReq_r |-> !(irqVec_r inside {[7'h08:7'h3C], [7'h78:7'h7F]}))
    else $error("offer lands on a software or reserved slot");
  a_idle_zero: assert property (
    !irqReq_r |-> irqVec_r == 7'h00 && irqPrio_r == 5'h00)
    else $error("idle offer not cleared");
  a_reset_first: assert property (
    hwResetReq |=> irqReq_r && irqVec_r == 7'h00 && irqPrio_r == 5'h01)
    else $error("reset request not offered first");
  a_nmi_next: assert property (
    nmiReq |=> irqReq_r && irqPrio_r inside {[1:2]})
    else $error("nonmaskable request not offered");
  a_enable_gate: assert property (
    irqPrio_r > 5'h02 |-> $past(cpuIntEnable))
    else $error("maskable offer without global enable");
  a_trap_sw_vec: assert property (
    s_trap_sw |=> trapVld_r && trapVec_r == {$past(trapNum), 2'b00} - 7'h3C)
    else $error("software trap vector wrong");
  a_trap_refuse: assert property (
    s_trap_bad |=> !trapVld_r)
    else $error("unused trap number produced a vector");
  a_read_cycle: assert property (
    regRdData_r != 16'h0000 |-> $past(regRdEn))
    else $error("read data outside its cycle");
endmodule

bind ivp_irq_vector ivp_props ivp_props_i (.*);

//--- tb/ivp_core_model.sv
// Purpose: Core side that takes offered vectors
// Assumes: Offer stays up until taken
// Notes:   Ack delay is set by the bench, so fast and slow cores both run
`timescale 1ns/1ps
module ivp_core_model (
  input  logic core_clk, // Processor clock
  input  logic rst_b,    // Reset, active low
  input  logic irqReq_r, // Offer from the vector block
  input  int   ackDelay, // Cycles an offer waits before it is taken
  output logic irqAck    // One-cycle take pulse
);
  int waitCnt;
  // Count how long the offer stood; the count restarts after each take
  always @(posedge core_clk)
    if (!rst_b || !irqReq_r || irqAck)
    begin
      waitCnt <= 0;
      irqAck  <= 1'b0;
    end
    else
    begin
      waitCnt <= waitCnt + 1;
      irqAck  <= (waitCnt + 1 >= ackDelay);
    end
endmodule

//--- tb/tb_interrupt_vector_priority.sv
// Purpose: Self-checking bench for the vector and priority block
// Assumes: Core model acks every offer after a set delay
// Notes:   Event bits 0-10 peripherals, 11-16 DMA, 17 nmi, 18-19 resets
`timescale 1ns/1ps
`include "ivp_defs.vh"
module tb_interrupt_vector_priority;
  logic core_clk, rst_b, regWrEn, regRdEn, cpuIntEnable, irqAck, irqReq_r;
  logic soft_vector_trap, trapVld_r, hwResetReq, softResetReq, nmiReq;
  logic ext_user_irq_0, ext_user_irq_1, ext_user_irq_2, ext_user_irq_3;
  logic timer_zero_irq, timer_one_irq, serial0_rx_irq, serial0_tx_irq;
  logic serial1_rx_irq, serial1_tx_irq, host_port_irq;
  logic [5:0]  dmaChIrq;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData_r;
  logic [4:0]  trapNum, irqPrio_r;
  logic [6:0]  irqVec_r, trapVec_r;
  logic [19:0] evt;
  integer      seed;
  int          fails, checks, ackDelay, i, j, b, n;
  int          pBit[11] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 10, 11};
  int          dBit[6] = '{6, 7, 10, 11, 12, 13};
  // One vector drives every event input so sources can fire together
  assign {softResetReq, hwResetReq, nmiReq, dmaChIrq, serial1_tx_irq,
    serial1_rx_irq, host_port_irq, ext_user_irq_3, timer_one_irq,
    serial0_tx_irq, serial0_rx_irq, timer_zero_irq, ext_user_irq_2,
    ext_user_irq_1, ext_user_irq_0} = evt;
  ivp_irq_vector ivp_irq_vector_i (.*);
  ivp_core_model ivp_core_model_i (.*);
  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic int bitOf(input int k);
    return k < 11 ? pBit[k] : dBit[k - 11];
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn   <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData_r, exp);
  endtask
  task automatic fire(input logic [19:0] m);
    @(posedge core_clk);
    evt <= m;
    @(posedge core_clk);
    evt <= 20'h00000;
    #1;
  endtask
  // Bounded wait for the core to take everything, then clear flags
  task automatic drain;
    for (int k = 0; k < 80 && irqReq_r !== 1'b0; k++)
      @(posedge core_clk) #1;
    chk(irqReq_r, 16'h0000);
    wr(`IVP_FLAG_ADDR, 16'h3FFF);
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #300000;
    fails++;
    conclude;
  end
  initial
  begin
    seed = 88;
    evt = 20'h00000;
    {regWrEn, regRdEn, soft_vector_trap} = 3'h0;
    {regAddr, regWrData, trapNum} = 29'h0;
    cpuIntEnable = 1'b1;
    ackDelay = 5;
    rst_b = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    for (i = 0; i < 4; i++)
      rd(i[7:0], 16'h0000);
    rd(8'($random(seed) | 4), 16'h0000);
    wr(`IVP_MASK_ADDR, 16'hFFFF);
    wr(8'($random(seed) | 4), 16'h0000);
    rd(`IVP_MASK_ADDR, 16'h3FFF);
    wr(`IVP_DSEL_ADDR, 16'hFFFF);
    rd(`IVP_DSEL_ADDR, 16'h000F);
    // Every maskable source under both shared-slot selections
    for (j = 0; j < 2; j++)
    begin
      wr(`IVP_DSEL_ADDR, j ? 16'h000F : 16'h0000);
      for (i = 0; i < 17; i++)
      begin
        b = bitOf(i);
        if (j ? (i < 11 && (b == 7 || b >= 10)) : (i > 10 && i < 15))
          b = -1;
        fire(20'h1 << i);
        chk(irqReq_r, b >= 0);
        chk(irqVec_r, b >= 0 ? 16'h40 + 4 * b : 0);
        chk(irqPrio_r, b >= 0 ? b + 3 : 0);
        rd(`IVP_FLAG_ADDR, b >= 0 ? 16'h1 << b : 16'h0);
        drain;
      end
    end
    // Random pairs firing together; the lower priority number wins
    wr(`IVP_DSEL_ADDR, 16'h0000);
    for (n = 0; n < 30; n++)
    begin
      ackDelay = 2 + $unsigned($random(seed)) % 4;
      i = $unsigned($random(seed)) % 13;
      j = $unsigned($random(seed)) % 13;
      i = i > 10 ? i + 4 : i;
      j = j > 10 ? j + 4 : j;
      b = bitOf(i) < bitOf(j) ? bitOf(i) : bitOf(j);
      fire((20'h1 << i) | (20'h1 << j));
      chk(irqPrio_r, b + 3);
      drain;
    end
    // Global enable and mask hold a flag back until they open
    cpuIntEnable <= 1'b0;
    fire(20'h00002);
    chk(irqReq_r, 16'h0000);
    wr(`IVP_MASK_ADDR, 16'h3FFD);
    cpuIntEnable <= 1'b1;
    @(posedge core_clk) #1;
    chk(irqReq_r, 16'h0000);
    wr(`IVP_MASK_ADDR, 16'h3FFF);
    @(posedge core_clk) #1;
    chk(irqVec_r, 16'h0044);
    drain;
    // Reset beats the nonmaskable request, which follows it
    fire(20'h60000);
    chk(irqVec_r, 16'h0000);
    for (i = 0; i < 20 && irqPrio_r !== 5'h02; i++)
      @(posedge core_clk) #1;
    chk(irqVec_r, 16'h0004);
    drain;
    fire(20'h80000);
    chk(irqPrio_r, 16'h0001);
    drain;
    // All trap numbers; unused ones give no pulse
    for (n = 0; n < 32; n++)
    begin
      @(posedge core_clk);
      soft_vector_trap <= 1'b1;
      trapNum          <= n[4:0];
      @(posedge core_clk);
      soft_vector_trap <= 1'b0;
      #1;
      chk(trapVld_r, !(n == 14 || n == 15 || n == 31));
      if (trapVld_r === 1'b1)
        chk(trapVec_r, n == 0 ? 0 : n < 14 ? 16'h40 + 4 * n :
          n == 16 ? 4 : 8 + 4 * (n - 17));
    end
    conclude;
  end
endmodule
